// ==== rtl/rlpc_cfg.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the color led controller
// Assumes: 100 MHz system clock
// Notes:   definitions only
`ifndef RLPC_CFG_SVH
`define RLPC_CFG_SVH

`define RLPC_CTRL_ADDR      8'h00
`define RLPC_COLOR_ADDR     8'h01

`define RLPC_CTRL_RESET     8'h20
`define RLPC_COLOR_RESET    8'h00
// bits 4 and 0 of the control register are not implemented
`define RLPC_CTRL_MASK      8'hee

`define RLPC_BIT_PWM_SEL    7
`define RLPC_BIT_OUT_EN     6
`define RLPC_BIT_MODE_SEL   5

`define RLPC_CLK_PERIOD_NS  10
`define RLPC_FRAME_US       50
`define RLPC_FRAME_CYCLES   ((`RLPC_FRAME_US * 1000) / `RLPC_CLK_PERIOD_NS)
// colour shares are counted in twelfths of the lit part of a frame
`define RLPC_SHARE_DIV      12
`define RLPC_BRIGHT_MAX     3'h7

`endif

// ==== rtl/rlpc_channel.sv ====
// Purpose: one color output, lit while the frame count lies inside its window
// Assumes: window bounds and count share one clock
// Notes:   an empty window (end not above start) keeps the output off
module rlpc_channel #(
    parameter int CW = 13
) (
    input  wire logic          clk,        // system clock
    input  wire logic          reset_n,    // synchronous reset, active low
    input  wire logic          active,     // channel allowed to light
    input  wire logic [CW-1:0] win_start,  // first lit count
    input  wire logic [CW-1:0] win_end,    // first dark count after the window
    input  wire logic [CW-1:0] count,      // frame count
    output logic               led_on      // registered drive of the output
);
    logic next_led_on;

    always_comb begin
        next_led_on = active && (count >= win_start) && (count < win_end);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            led_on <= 1'b0;
        end else begin
            led_on <= next_led_on;
        end
    end
endmodule

// ==== rtl/rlpc_frame_timer.sv ====
// Purpose: frame counter that paces slots and duty of the color outputs
// Assumes: clear comes from same-clock logic
// Notes:   frame_start pulses on the cycle the count is back at zero after a wrap
module rlpc_frame_timer #(
    parameter int FRAME_CYCLES = 5000,
    parameter int CW           = 13
) (
    input  wire logic          clk,         // system clock
    input  wire logic          reset_n,     // synchronous reset, active low
    input  wire logic          clear,       // hold count at zero
    output logic [CW-1:0]      count,       // cycle within frame
    output logic               frame_start  // one-cycle pulse at each new frame
);
    localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);

    logic [CW-1:0] next_count;
    logic          next_frame_start;

    always_comb begin
        next_frame_start = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (count == LAST) begin
            next_count       = '0;
            next_frame_start = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count       <= '0;
            frame_start <= 1'b0;
        end else begin
            count       <= next_count;
            frame_start <= next_frame_start;
        end
    end
endmodule

// ==== rtl/rlpc_pkg.sv ====
// Purpose: types shared by the color led controller
// Assumes: nothing
// Notes:   constants live in rlpc_cfg.svh
package rlpc_pkg;

    typedef struct packed {
        logic internal_pwm_select;
        logic color_outputs_enable;
        logic output_mode_select;
        logic rsv4;
        logic red_channel_enable;
        logic green_channel_enable;
        logic blue_channel_enable;
        logic rsv0;
    } rlpc_ctrl_t;

    typedef struct packed {
        logic [3:0] color_code;
        logic [2:0] bright_code;
        logic       overlap_select;
    } rlpc_color_t;

    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } rlpc_share_t;

    typedef enum logic [1:0] {
        RLPC_DRIVE_OFF,
        RLPC_DRIVE_DIRECT,
        RLPC_DRIVE_OVERLAP,
        RLPC_DRIVE_SLOTS
    } rlpc_drive_t;

endpackage

// ==== rtl/rlpc_top.sv ====
// Purpose: register-driven pwm control of a three-channel color led output
// Assumes: register port driven from same-clock logic; 100 MHz clock
// Notes:   slot windows use whole twelfths of the frame, so a few cycles at frame end stay dark
//
// Summary of operation
// - mode bit high gives low-ohmic switches, low gives constant current sinks.
// - pwm select low clears internal pwm; output enable low turns all outputs off.
// - red, green, blue enable bits gate their own outputs.
// - colour register holds colour code 7:4, brightness 3:1, overlap select 0.
// - overlap select one means overlapping, zero means non-overlapping.
// - brightness codes give zero, then 1/64 doubling up to full on-time.
// - colour codes 0 to 6 give primaries, pairs and even white shares.
// - colour codes 7 to 15 give the mixed 25/50/75 percent shares.
// - colour code only matters in non-overlapping mode.
// - overlapping mode lights all enabled outputs together with one common duty.
// - non-overlapping mode splits each 50 us frame into separate colour slots.
// - reduced brightness shortens every slot, outputs stay dark for frame remainder.
// - outputs enabled without internal pwm follow the channel enables directly.
`include "rlpc_cfg.svh"

module rlpc_top #(
    parameter int FRAME_CYCLES = `RLPC_FRAME_CYCLES,
    parameter int CW           = $clog2(FRAME_CYCLES + 1)
) (
    input  wire logic       clk,          // system clock
    input  wire logic       reset_n,      // synchronous reset, active low
    input  wire logic [7:0] reg_addr,     // register address
    input  wire logic [7:0] reg_wdata,    // write data
    input  wire logic       reg_write,    // write strobe
    output logic      [7:0] reg_rdata,    // read data of reg_addr, one cycle later
    output logic            red_output,   // red drive, high = on
    output logic            green_output, // green drive, high = on
    output logic            blue_output,  // blue drive, high = on
    output logic            switch_mode   // high = switch, low = current sink
);
    localparam logic [CW-1:0] FRAME_LEN = CW'(FRAME_CYCLES);
    localparam logic [CW-1:0] UNIT_LEN  = CW'(FRAME_CYCLES / `RLPC_SHARE_DIV);
    localparam logic [CW-1:0] LAST      = CW'(FRAME_CYCLES - 1);

    rlpc_pkg::rlpc_ctrl_t  ctrl;
    rlpc_pkg::rlpc_ctrl_t  next_ctrl;
    rlpc_pkg::rlpc_color_t color;
    rlpc_pkg::rlpc_color_t next_color;
    logic [7:0]            next_reg_rdata;
    logic                  next_switch_mode;

    rlpc_pkg::rlpc_drive_t drive;
    rlpc_pkg::rlpc_share_t share;
    logic [2:0]            shift;
    logic [CW-1:0]         full_len;
    logic [CW-1:0]         unit_len;
    logic [CW+3:0]         prod_red;
    logic [CW+3:0]         prod_green;
    logic [CW+3:0]         prod_blue;
    logic [CW-1:0]         red_end;
    logic [CW-1:0]         green_end;
    logic [CW-1:0]         blue_end;
    logic [2:0]            ch_en;
    logic [2:0]            ch_active;
    logic [CW-1:0]         win_start [3];
    logic [CW-1:0]         win_end   [3];
    logic [2:0]            ch_out;
    logic [CW-1:0]         count;
    logic                  frame_start;

    // colour code to red/green/blue shares in twelfths
    function automatic rlpc_pkg::rlpc_share_t color_share(input logic [3:0] code);
        rlpc_pkg::rlpc_share_t s;
        s = '0;
        case (code)
            4'h0: s = '{4'hc, 4'h0, 4'h0};
            4'h1: s = '{4'h0, 4'hc, 4'h0};
            4'h2: s = '{4'h0, 4'h0, 4'hc};
            4'h3: s = '{4'h6, 4'h6, 4'h0};
            4'h4: s = '{4'h0, 4'h6, 4'h6};
            4'h5: s = '{4'h6, 4'h0, 4'h6};
            4'h6: s = '{4'h4, 4'h4, 4'h4};
            4'h7: s = '{4'h6, 4'h3, 4'h3};
            4'h8: s = '{4'h3, 4'h6, 4'h3};
            4'h9: s = '{4'h3, 4'h6, 4'h3};
            4'ha: s = '{4'h3, 4'h3, 4'h6};
            4'hb: s = '{4'h9, 4'h3, 4'h0};
            4'hc: s = '{4'h0, 4'h9, 4'h3};
            4'hd: s = '{4'h3, 4'h9, 4'h0};
            4'he: s = '{4'h0, 4'h3, 4'h9};
            4'hf: s = '{4'h3, 4'h0, 4'h9};
            default: s = '0;
        endcase
        return s;
    endfunction

    // register file
    always_comb begin
        next_ctrl  = ctrl;
        next_color = color;
        if (reg_write) begin
            case (reg_addr)
                `RLPC_CTRL_ADDR:  next_ctrl  = rlpc_pkg::rlpc_ctrl_t'(reg_wdata & `RLPC_CTRL_MASK);
                `RLPC_COLOR_ADDR: next_color = rlpc_pkg::rlpc_color_t'(reg_wdata);
                default: ;
            endcase
        end
        case (reg_addr)
            `RLPC_CTRL_ADDR:  next_reg_rdata = ctrl;
            `RLPC_COLOR_ADDR: next_reg_rdata = color;
            default:          next_reg_rdata = 8'h00;
        endcase
        next_switch_mode = ctrl.output_mode_select;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl        <= rlpc_pkg::rlpc_ctrl_t'(`RLPC_CTRL_RESET);
            color       <= rlpc_pkg::rlpc_color_t'(`RLPC_COLOR_RESET);
            reg_rdata   <= 8'h00;
            switch_mode <= 1'(`RLPC_CTRL_RESET >> `RLPC_BIT_MODE_SEL);
        end else begin
            ctrl        <= next_ctrl;
            color       <= next_color;
            reg_rdata   <= next_reg_rdata;
            switch_mode <= next_switch_mode;
        end
    end

    // drive selection and slot windows
    always_comb begin
        if (!ctrl.color_outputs_enable) begin
            drive = rlpc_pkg::RLPC_DRIVE_OFF;
        end else if (!ctrl.internal_pwm_select) begin
            drive = rlpc_pkg::RLPC_DRIVE_DIRECT;
        end else if (color.overlap_select) begin
            drive = rlpc_pkg::RLPC_DRIVE_OVERLAP;
        end else begin
            drive = rlpc_pkg::RLPC_DRIVE_SLOTS;
        end

        shift = `RLPC_BRIGHT_MAX - color.bright_code;
        if (color.bright_code == 3'h0) begin
            full_len = '0;
            unit_len = '0;
        end else begin
            full_len = FRAME_LEN >> shift;
            unit_len = UNIT_LEN >> shift;
        end

        share      = color_share(color.color_code);
        prod_red   = {4'h0, unit_len} * share.red;
        prod_green = {4'h0, unit_len} * share.green;
        prod_blue  = {4'h0, unit_len} * share.blue;
        red_end    = prod_red[CW-1:0];
        green_end  = red_end + prod_green[CW-1:0];
        blue_end   = green_end + prod_blue[CW-1:0];

        ch_en = {ctrl.blue_channel_enable, ctrl.green_channel_enable, ctrl.red_channel_enable};
        for (int i = 0; i < 3; i++) begin
            win_start[i] = '0;
            win_end[i]   = '0;
        end
        ch_active = 3'h0;
        case (drive)
            rlpc_pkg::RLPC_DRIVE_OFF: begin
                ch_active = 3'h0;
            end
            rlpc_pkg::RLPC_DRIVE_DIRECT: begin
                // count is held at zero, so a full-frame window is steady on
                ch_active = ch_en;
                for (int i = 0; i < 3; i++) begin
                    win_end[i] = FRAME_LEN;
                end
            end
            rlpc_pkg::RLPC_DRIVE_OVERLAP: begin
                ch_active = ch_en;
                for (int i = 0; i < 3; i++) begin
                    win_end[i] = full_len;
                end
            end
            rlpc_pkg::RLPC_DRIVE_SLOTS: begin
                ch_active    = ch_en;
                win_end[0]   = red_end;
                win_start[1] = red_end;
                win_end[1]   = green_end;
                win_start[2] = green_end;
                win_end[2]   = blue_end;
            end
            default: begin
                ch_active = 3'h0;
            end
        endcase
    end

    rlpc_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES),
        .CW           (CW)
    ) u_timer (
        .clk         (clk),
        .reset_n     (reset_n),
        .clear       (!ctrl.internal_pwm_select),
        .count       (count),
        .frame_start (frame_start)
    );

    for (genvar g = 0; g < 3; g++) begin : gen_ch
        rlpc_channel #(
            .CW (CW)
        ) u_ch (
            .clk       (clk),
            .reset_n   (reset_n),
            .active    (ch_active[g]),
            .win_start (win_start[g]),
            .win_end   (win_end[g]),
            .count     (count),
            .led_on    (ch_out[g])
        );
    end

    assign red_output   = ch_out[0];
    assign green_output = ch_out[1];
    assign blue_output  = ch_out[2];

    property p_mode_follows_write;
        @(posedge clk) disable iff (!reset_n)
        (reg_write && reg_addr == `RLPC_CTRL_ADDR)
            |-> ##2 switch_mode == $past(reg_wdata[`RLPC_BIT_MODE_SEL], 2);
    endproperty
    a_mode_follows_write: assert property (p_mode_follows_write) else $error("switch mode not from control write");

    property p_all_off;
        @(posedge clk) disable iff (!reset_n)
        !ctrl.color_outputs_enable |=> !red_output && !green_output && !blue_output;
    endproperty
    a_all_off: assert property (p_all_off) else $error("output lit while outputs disabled");

    property p_pwm_cleared;
        @(posedge clk) disable iff (!reset_n)
        !ctrl.internal_pwm_select |=> count == '0 && !frame_start;
    endproperty
    a_pwm_cleared: assert property (p_pwm_cleared) else $error("frame count runs with pwm deselected");

    property p_red_gate;
        @(posedge clk) disable iff (!reset_n)
        !ctrl.red_channel_enable |=> !red_output;
    endproperty
    a_red_gate: assert property (p_red_gate) else $error("red lit while its enable is low");

    property p_direct_on;
        @(posedge clk) disable iff (!reset_n)
        (drive == rlpc_pkg::RLPC_DRIVE_DIRECT) |=> red_output == $past(ctrl.red_channel_enable)
            && blue_output == $past(ctrl.blue_channel_enable);
    endproperty
    a_direct_on: assert property (p_direct_on) else $error("direct drive does not follow enables");

    property p_slots_apart;
        @(posedge clk) disable iff (!reset_n)
        (drive == rlpc_pkg::RLPC_DRIVE_SLOTS) |=> $onehot0({red_output, green_output, blue_output});
    endproperty
    a_slots_apart: assert property (p_slots_apart) else $error("colour slots overlap");

    property p_overlap_together;
        @(posedge clk) disable iff (!reset_n)
        (drive == rlpc_pkg::RLPC_DRIVE_OVERLAP && &ch_en && count < full_len)
            |=> red_output && green_output && blue_output;
    endproperty
    a_overlap_together: assert property (p_overlap_together) else $error("overlap outputs not on together");

    property p_frame_wrap;
        @(posedge clk) disable iff (!reset_n)
        (ctrl.internal_pwm_select && count == LAST) ##1 ctrl.internal_pwm_select
            |-> count == '0 && frame_start;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame does not restart after last count");

    property p_dark_tail;
        @(posedge clk) disable iff (!reset_n)
        (drive == rlpc_pkg::RLPC_DRIVE_SLOTS && count >= blue_end)
            |=> !red_output && !green_output && !blue_output;
    endproperty
    a_dark_tail: assert property (p_dark_tail) else $error("output lit after shortened slots");

    property p_zero_bright;
        @(posedge clk) disable iff (!reset_n)
        (ctrl.internal_pwm_select && color.bright_code == 3'h0)
            |=> !red_output && !green_output && !blue_output;
    endproperty
    a_zero_bright: assert property (p_zero_bright) else $error("output lit at brightness zero");

    property p_red_full;
        @(posedge clk) disable iff (!reset_n)
        (drive == rlpc_pkg::RLPC_DRIVE_SLOTS && color.color_code == 4'h0 && ctrl.red_channel_enable
            && color.bright_code == `RLPC_BRIGHT_MAX && count < UNIT_LEN * `RLPC_SHARE_DIV)
            |=> red_output && !green_output;
    endproperty
    a_red_full: assert property (p_red_full) else $error("red colour code does not fill the frame");
endmodule

// ==== sim/rlpc_led_model.sv ====
// Purpose: passive model of a three-colour led on the sink outputs, counting lit cycles over one frame window
// Assumes: outputs are registered on the same clock; high = led lit
// Notes:   a window is exactly one frame long, so its counts do not depend on frame phase
module rlpc_led_model #(
    parameter int FRAME_CYCLES = 120
) (
    input  wire logic        clk,          // system clock
    input  wire logic        red_on,       // red sink active
    input  wire logic        green_on,     // green sink active
    input  wire logic        blue_on,      // blue sink active
    input  wire logic        start,        // begin a one-frame window
    output logic             busy,         // window running
    output logic      [15:0] red_cnt,      // lit cycles of red
    output logic      [15:0] green_cnt,    // lit cycles of green
    output logic      [15:0] blue_cnt,     // lit cycles of blue
    output logic      [15:0] rise_cnt,     // turn-on events of all channels
    output logic      [15:0] clash_cnt,    // cycles with two or more lit together
    output logic      [15:0] uneven_cnt    // cycles where the three differ
);
    timeunit 1ns;
    timeprecision 1ps;

    int         win = 0;
    logic [2:0] prev = 3'h0;
    logic [2:0] now;

    assign now  = {red_on, green_on, blue_on};
    assign busy = (win != 0);

    always_ff @(posedge clk) begin
        prev <= now;
        if (start) begin
            win        <= FRAME_CYCLES;
            red_cnt    <= 16'h0;
            green_cnt  <= 16'h0;
            blue_cnt   <= 16'h0;
            rise_cnt   <= 16'h0;
            clash_cnt  <= 16'h0;
            uneven_cnt <= 16'h0;
        end else if (win > 0) begin
            win        <= win - 1;
            red_cnt    <= red_cnt + 16'(red_on);
            green_cnt  <= green_cnt + 16'(green_on);
            blue_cnt   <= blue_cnt + 16'(blue_on);
            rise_cnt   <= rise_cnt + 16'($countones(now & ~prev));
            clash_cnt  <= clash_cnt + 16'($countones(now) > 1);
            uneven_cnt <= uneven_cnt + 16'(!(now == 3'h0 || now == 3'h7));
        end
    end
endmodule

// ==== sim/rlpc_top_test.sv ====
// Purpose: self-checking bench of the colour led controller
// Assumes: frame shortened to 120 cycles, so one twelfth is 10 cycles
// Notes:   inputs change on the falling edge of the clock
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("BAD %0t %s got %0h exp %0h", $time, tname, got, exp); end end

module rlpc_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int FC = 120;
    localparam int U  = FC / 12;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        reg_write = 1'b0;
    logic        start = 1'b0;
    logic  [7:0] reg_addr = 8'h00;
    logic  [7:0] reg_wdata = 8'h00;
    logic  [7:0] reg_rdata;
    logic        red_output, green_output, blue_output, switch_mode, busy;
    logic [15:0] red_cnt, green_cnt, blue_cnt, rise_cnt, clash_cnt, uneven_cnt;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          u;
    string       tname = "reset";
    // red, green, blue shares in twelfths per colour code
    logic [11:0] share [16] = '{12'hc00, 12'h0c0, 12'h00c, 12'h660, 12'h066, 12'h606, 12'h444, 12'h633,
                                12'h363, 12'h363, 12'h336, 12'h930, 12'h093, 12'h390, 12'h039, 12'h309};

    always #5 clk = ~clk;

    rlpc_top #(.FRAME_CYCLES(FC)) u_dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_rdata(reg_rdata), .red_output(red_output), .green_output(green_output),
        .blue_output(blue_output), .switch_mode(switch_mode));

    rlpc_led_model #(.FRAME_CYCLES(FC)) u_led (
        .clk(clk), .red_on(red_output), .green_on(green_output), .blue_on(blue_output), .start(start),
        .busy(busy), .red_cnt(red_cnt), .green_cnt(green_cnt), .blue_cnt(blue_cnt), .rise_cnt(rise_cnt),
        .clash_cnt(clash_cnt), .uneven_cnt(uneven_cnt));

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("BAD %0t run did not finish", $time);
            wrap_up();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        `CHK(reg_rdata, exp)
    endtask

    // one frame window of the led model, then compare lit cycles
    task automatic meas(input int er, input int eg, input int eb);
        repeat (3) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < 200 && busy; i++) @(negedge clk);
        `CHK(red_cnt, 16'(er))
        `CHK(green_cnt, 16'(eg))
        `CHK(blue_cnt, 16'(eb))
    endtask

    function automatic int parts(input logic [11:0] s);
        int n;
        n = 0;
        for (int k = 0; k < 3; k++) n += (s[k*4 +: 4] > 0 && s[k*4 +: 4] < 12) ? 1 : 0;
        return n;
    endfunction

    task automatic done;
        $display("test %s finished", tname);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        `CHK(switch_mode, 1'b1)
        `CHK({red_output, green_output, blue_output}, 3'b000)
        reset_n = 1'b1;
        rd_chk(8'h00, 8'h20);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h07, 8'h00);
        wr(8'h00, 8'hff);
        rd_chk(8'h00, 8'hee);
        wr(8'h01, 8'h5b);
        rd_chk(8'h01, 8'h5b);
        done();

        tname = "mode";
        wr(8'h00, 8'h4e);
        @(negedge clk);
        `CHK(switch_mode, 1'b0)
        wr(8'h00, 8'h6e);
        @(negedge clk);
        `CHK(switch_mode, 1'b1)
        done();

        tname = "direct";
        wr(8'h01, 8'h0e);
        for (int e = 0; e < 8; e++) begin
            wr(8'h00, 8'h40 | 8'(e << 1));
            meas(e[2] ? FC : 0, e[1] ? FC : 0, e[0] ? FC : 0);
        end
        wr(8'h00, 8'h8e);
        meas(0, 0, 0);
        wr(8'h00, 8'h0e);
        meas(0, 0, 0);
        done();

        tname = "colours";
        wr(8'h00, 8'hce);
        for (int c = 0; c < 16; c++) begin
            wr(8'h01, {c[3:0], 4'he});
            meas(U * share[c][11:8], U * share[c][7:4], U * share[c][3:0]);
            `CHK(clash_cnt, 16'h0)
            `CHK(rise_cnt, 16'(parts(share[c])))
        end
        done();

        tname = "brightness";
        for (int b = 0; b < 8; b++) begin
            wr(8'h01, {4'h6, b[2:0], 1'b0});
            u = (b == 0) ? 0 : (U >> (7 - b));
            meas(4 * u, 4 * u, 4 * u);
            `CHK(clash_cnt, 16'h0)
        end
        wr(8'h00, 8'hc4);
        wr(8'h01, 8'h6e);
        meas(0, 4 * U, 0);
        done();

        tname = "overlap";
        wr(8'h00, 8'hce);
        for (int c = 0; c < 2; c++) begin
            for (int b = 0; b < 8; b++) begin
                wr(8'h01, {(c == 0) ? 4'h0 : 4'hb, b[2:0], 1'b1});
                u = (b == 0) ? 0 : (FC >> (7 - b));
                meas(u, u, u);
                `CHK(uneven_cnt, 16'h0)
            end
        end
        wr(8'h00, 8'hca);
        wr(8'h01, 8'hbf);
        meas(FC, 0, FC);
        done();

        tname = "restart";
        wr(8'h01, 8'h0c);
        wr(8'h00, 8'h4e);
        wr(8'h00, 8'hce);
        repeat (30) @(negedge clk);
        `CHK(red_output, 1'b1)
        repeat (40) @(negedge clk);
        `CHK(red_output, 1'b0)
        done();

        wrap_up();
    end
endmodule
